// ---- core/rmi_pkg.sv ----
package rmi_pkg;
	// message codes handed over by the header parser (long and short spellings map to one code)
	typedef enum logic [4:0] {
		RMI_CLS    = 5'h00, RMI_ESR_Q  = 5'h01, RMI_IDN_Q  = 5'h02, RMI_RST    = 5'h03,
		RMI_SRE    = 5'h04, RMI_SRE_Q  = 5'h05, RMI_STB_Q  = 5'h06, RMI_BUZZ   = 5'h07,
		RMI_BUZZ_Q = 5'h08, RMI_FLUSH  = 5'h09, RMI_COM    = 5'h0A, RMI_COM_Q  = 5'h0B,
		RMI_LDC    = 5'h0C, RMI_LDC_Q  = 5'h0D, RMI_CUR    = 5'h0E, RMI_CUR_Q  = 5'h0F,
		RMI_DAC    = 5'h10, RMI_DAC_Q  = 5'h11, RMI_DSM    = 5'h12, RMI_DSM_Q  = 5'h13,
		RMI_DSR_Q  = 5'h14, RMI_ERR_Q  = 5'h15, RMI_FAIL_Q = 5'h16
	} rmi_code_t;
	localparam logic [4:0] RMI_LAST_CODE = 5'h16;   // highest known code

	// answer sequencer states
	typedef enum logic [1:0] {
		RMI_ST_IDLE = 2'b00,
		RMI_ST_IDN2 = 2'b01,
		RMI_ST_COMQ = 2'b10
	} rmi_state_t;

	// event status bits
	localparam int EXEC_FAULT_BIT = 4;
	localparam int CMD_FAULT_BIT  = 5;
	// error register bits
	localparam int ERR_SYNTAX_BIT = 0;
	localparam int ERR_DATA_BIT   = 1;
	localparam int ERR_RANGE_BIT  = 2;
	localparam int ERR_INVAL_BIT  = 3;
	// status byte summary bits
	localparam int STB_DSB_BIT = 3;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_RQS_BIT = 6;

	// setting limits and factory defaults
	localparam logic [15:0] MASK_MAX     = 16'h00FF;
	localparam logic [15:0] BUZZ_MIN     = 16'h0001;
	localparam logic [15:0] BUZZ_MAX     = 16'h000A;
	localparam logic [15:0] CUR_MIN      = 16'h001E;  // 3.0 A in 0.1 A steps
	localparam logic [15:0] CUR_MAX      = 16'h012C;  // 30.0 A
	localparam logic [3:0]  BUZZ_DEFAULT = 4'h5;
	localparam logic [8:0]  CUR_DEFAULT  = 9'h01E;
	localparam logic [7:0]  CHAR_MIN     = 8'h20;
	localparam logic [7:0]  CHAR_MAX     = 8'h7E;
	localparam logic [7:0]  CHAR_SPACE   = 8'h20;
	localparam int          COM_LINE_LEN = 20;
	localparam int          COM_LINES    = 3;
	localparam int          COM_CHARS    = 60;
	localparam logic [5:0]  COM_LAST_IX  = 6'h3B;
	// identity words, values arbitrary
	localparam logic [15:0] MODEL_WORD = 16'h0A51;
	localparam logic [15:0] ROM_WORD   = 16'h0100;
endpackage : rmi_pkg

// ---- core/rmi_interp.sv ----
`timescale 1ns/1ps
`default_nettype none
module rmi_interp (
	input  wire logic        sys_clk,         // 25 MHz clock
	input  wire logic        rst,             // async reset, active high
	input  wire logic        msg_valid,       // parsed message present
	output logic             msg_ready,       // interpreter can take a message
	input  wire logic [4:0]  msg_code,        // message code
	input  wire logic        msg_short,       // header came in short spelling
	input  wire logic [15:0] msg_data,        // numeric value or comment char
	input  wire logic        msg_syntax_err,  // parser saw a header fault
	input  wire logic        msg_data_err,    // parser saw a data fault
	input  wire logic        test_running,    // pin: test in progress
	input  wire logic        prot_active,     // pin: protection state
	input  wire logic        load_detect,     // pin: load connected
	input  wire logic [7:0]  dsr_set,         // device status events
	input  wire logic [7:0]  prot_set,        // protection events
	input  wire logic [7:0]  fail_set,        // fail judgment events
	input  wire logic [7:0]  invs_set,        // invalid setting events
	output logic             resp_valid,      // answer word present
	output logic [15:0]      resp_data,       // answer word
	output logic             resp_last,       // last word of answer
	output logic             flush,           // input buffer flush pulse
	output logic             test_start,      // contact check start pulse
	output logic [3:0]       buzzer_loudness, // buzzer setting
	output logic             contact_check,   // contact check enable
	output logic [8:0]       test_current,    // current in 0.1 A
	output logic             double_action,   // start double action
	output logic             srq              // service request
);
	// pin synchronisers, first stage read only by second
	logic [2:0] pin_s1;      // first stage
	logic [2:0] pin_s2;      // second stage
	logic       load_d;      // previous load level
	logic       test_q;      // synced test state
	logic       prot_q;      // synced protection state
	// status registers
	logic [7:0] esr;         // event status
	logic [7:0] dsr;         // device status
	logic [7:0] prot;        // protection
	logic [7:0] fail;        // fail judgment
	logic [7:0] invs;        // invalid setting
	logic [7:0] err;         // error register
	logic [7:0] sre;         // service request enable
	logic [7:0] device_status_mask_cmd;         // device status mask
	logic [7:0] stb;         // status byte, derived
	// comment store and answer sequencer
	localparam int COM_CHARS_L = rmi_pkg::COM_CHARS;
	logic [7:0] com_mem [0:COM_CHARS_L-1];
	logic [5:0] com_ix;      // next char to send
	rmi_pkg::rmi_state_t st; // sequencer state
	logic [15:0] query_val;  // value for single-word queries

	// decode of the current message
	logic acc;               // message taken
	logic known;             // code in table
	logic bad_range;         // value out of range
	logic fault;             // command fault
	logic blocked;           // not executable now
	logic exec;              // message carried out
	logic [5:0] wr_ix;       // comment write index

	// permitted during a test
	function automatic logic ok_in_test(input logic [4:0] c);
		case (c)
			rmi_pkg::RMI_SRE, rmi_pkg::RMI_BUZZ, rmi_pkg::RMI_COM, rmi_pkg::RMI_LDC,
			rmi_pkg::RMI_DAC, rmi_pkg::RMI_DSM: ok_in_test = 1'b0;
			default: ok_in_test = 1'b1;
		endcase
	endfunction : ok_in_test

	// permitted in protection: the test set plus current is refused
	function automatic logic ok_in_prot(input logic [4:0] c);
		ok_in_prot = ok_in_test(c) && (c != rmi_pkg::RMI_CUR);
	endfunction : ok_in_prot

	// printable and not a quote, comma or at-sign
	function automatic logic char_ok(input logic [7:0] ch);
		char_ok = (ch >= rmi_pkg::CHAR_MIN) && (ch <= rmi_pkg::CHAR_MAX) &&
			(ch != 8'h22) && (ch != 8'h27) && (ch != 8'h2C) && (ch != 8'h40);
	endfunction : char_ok

	// value check per setting
	function automatic logic out_of_range(input logic [4:0] c, input logic [15:0] d);
		case (c)
			rmi_pkg::RMI_SRE, rmi_pkg::RMI_DSM: out_of_range = d > rmi_pkg::MASK_MAX;
			rmi_pkg::RMI_BUZZ: out_of_range = (d < rmi_pkg::BUZZ_MIN) || (d > rmi_pkg::BUZZ_MAX);
			rmi_pkg::RMI_LDC, rmi_pkg::RMI_DAC: out_of_range = d > 16'h0001;
			rmi_pkg::RMI_CUR: out_of_range = (d < rmi_pkg::CUR_MIN) || (d > rmi_pkg::CUR_MAX);
			rmi_pkg::RMI_COM: out_of_range = !char_ok(d[7:0]) ||
				(d[12:8] >= 5'(rmi_pkg::COM_LINE_LEN)) || (d[14:13] >= 2'(rmi_pkg::COM_LINES));
			default: out_of_range = 1'b0;
		endcase
	endfunction : out_of_range

	// pin synchronisers and load edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
			load_d <= 1'b0;
		end else begin
			pin_s1 <= {load_detect, prot_active, test_running};
			pin_s2 <= pin_s1;
			load_d <= pin_s2[2];
		end
	end
	assign test_q = pin_s2[0];
	assign prot_q = pin_s2[1];

	// a message is only taken while no multi-word answer is running
	assign msg_ready = (st == rmi_pkg::RMI_ST_IDLE);
	assign acc       = msg_valid && msg_ready;
	assign known     = msg_code <= rmi_pkg::RMI_LAST_CODE;
	assign bad_range = out_of_range(msg_code, msg_data);
	assign fault     = acc && (msg_syntax_err || !known || msg_data_err || bad_range);
	assign blocked   = acc && !fault &&
		((test_q && !ok_in_test(msg_code)) || (prot_q && !ok_in_prot(msg_code)));
	// short flag plays no part in the decision
	assign exec      = acc && !fault && !blocked;
	// widen before the product, line 2 times 20 needs six bits
	assign wr_ix     = (6'(msg_data[14:13]) * 6'h14) + 6'(msg_data[12:8]);

	// event status: fault bit set wins over the clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			esr <= 8'h00;
		end else begin
			if (exec && (msg_code == rmi_pkg::RMI_CLS || msg_code == rmi_pkg::RMI_ESR_Q)) begin
				esr <= 8'h00;
			end
			if (blocked) begin
				esr[rmi_pkg::EXEC_FAULT_BIT] <= 1'b1;
			end
			if (fault) begin
				esr[rmi_pkg::CMD_FAULT_BIT] <= 1'b1;
			end
		end
	end

	// sticky status registers fed by the test engine, plus the error register fed by message faults
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dsr  <= 8'h00;
			prot <= 8'h00;
			fail <= 8'h00;
			invs <= 8'h00;
			err  <= 8'h00;
		end else begin
			// clear together, set ORed in afterwards
			if (exec && msg_code == rmi_pkg::RMI_CLS) begin
				dsr  <= dsr_set;
				prot <= prot_set;
				fail <= fail_set;
				invs <= invs_set;
				err  <= 8'h00;
			end else begin
				dsr  <= dsr | dsr_set;
				prot <= prot | prot_set;
				fail <= fail | fail_set;
				invs <= invs | invs_set;
			end
			// error detail bits
			if (fault && (msg_syntax_err || !known)) begin
				err[rmi_pkg::ERR_SYNTAX_BIT] <= 1'b1;
			end
			if (fault && msg_data_err) begin
				err[rmi_pkg::ERR_DATA_BIT] <= 1'b1;
			end
			if (fault && bad_range) begin
				err[rmi_pkg::ERR_RANGE_BIT] <= 1'b1;
			end
			if (blocked) begin
				err[rmi_pkg::ERR_INVAL_BIT] <= 1'b1;
			end
		end
	end

	// status byte is a live summary, so clearing its sources clears it
	always_comb begin
		stb = 8'h00;
		stb[rmi_pkg::STB_DSB_BIT] = |(dsr & device_status_mask_cmd);
		stb[rmi_pkg::STB_ESB_BIT] = |esr;
		stb[rmi_pkg::STB_RQS_BIT] = |(stb & sre);
	end
	assign srq = stb[rmi_pkg::STB_RQS_BIT];

	// enable masks survive a device reset, they belong to the interface
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sre <= 8'h00;
			device_status_mask_cmd <= 8'h00;
		end else if (exec) begin
			if (msg_code == rmi_pkg::RMI_SRE) begin
				sre <= msg_data[7:0];
			end
			if (msg_code == rmi_pkg::RMI_DSM) begin
				device_status_mask_cmd <= msg_data[7:0];
			end
		end
	end

	// instrument settings
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			buzzer_loudness <= rmi_pkg::BUZZ_DEFAULT;
			contact_check   <= 1'b0;
			test_current    <= rmi_pkg::CUR_DEFAULT;
			double_action   <= 1'b0;
		end else if (exec) begin
			case (msg_code)
				rmi_pkg::RMI_RST: begin
					buzzer_loudness <= rmi_pkg::BUZZ_DEFAULT;
					contact_check   <= 1'b0;
					test_current    <= rmi_pkg::CUR_DEFAULT;
					double_action   <= 1'b0;
				end
				rmi_pkg::RMI_BUZZ: buzzer_loudness <= msg_data[3:0];
				rmi_pkg::RMI_LDC: contact_check <= msg_data[0];
				rmi_pkg::RMI_CUR: test_current <= msg_data[8:0];
				rmi_pkg::RMI_DAC: double_action <= msg_data[0];
				default: begin
				end
			endcase
		end
	end

	// comment store, blanked by reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < COM_CHARS_L; i++) begin
				com_mem[i] <= rmi_pkg::CHAR_SPACE;
			end
		end else if (exec && msg_code == rmi_pkg::RMI_RST) begin
			for (int i = 0; i < COM_CHARS_L; i++) begin
				com_mem[i] <= rmi_pkg::CHAR_SPACE;
			end
		end else if (exec && msg_code == rmi_pkg::RMI_COM) begin
			com_mem[wr_ix] <= msg_data[7:0];
		end
	end

	// flush and contact-check start pulses
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flush      <= 1'b0;
			test_start <= 1'b0;
		end else begin
			// flush pulse to the input buffer
			flush      <= exec && msg_code == rmi_pkg::RMI_FLUSH;
			test_start <= contact_check && pin_s2[2] && !load_d && !test_q && !prot_q;
		end
	end

	// value of each single-word query
	always_comb begin
		query_val = 16'h0000;
		case (msg_code)
			rmi_pkg::RMI_ESR_Q:  query_val = {8'h00, esr};
			rmi_pkg::RMI_SRE_Q:  query_val = {8'h00, sre};
			rmi_pkg::RMI_STB_Q:  query_val = {8'h00, stb};
			rmi_pkg::RMI_BUZZ_Q: query_val = {12'h000, buzzer_loudness};
			rmi_pkg::RMI_LDC_Q:  query_val = {15'h0000, contact_check};
			rmi_pkg::RMI_CUR_Q:  query_val = {7'h00, test_current};
			rmi_pkg::RMI_DAC_Q:  query_val = {15'h0000, double_action};
			rmi_pkg::RMI_DSM_Q:  query_val = {8'h00, device_status_mask_cmd};
			rmi_pkg::RMI_DSR_Q:  query_val = {8'h00, dsr};
			rmi_pkg::RMI_ERR_Q:  query_val = {8'h00, err};
			rmi_pkg::RMI_FAIL_Q: query_val = {8'h00, fail};
			rmi_pkg::RMI_IDN_Q:  query_val = rmi_pkg::MODEL_WORD;
			default:             query_val = 16'h0000;
		endcase
	end

	// answer sequencer; multi-word answers hold off new messages
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st         <= rmi_pkg::RMI_ST_IDLE;
			com_ix     <= 6'h00;
			resp_valid <= 1'b0;
			resp_data  <= 16'h0000;
			resp_last  <= 1'b0;
		end else begin
			resp_valid <= 1'b0;
			resp_last  <= 1'b0;
			case (st)
				rmi_pkg::RMI_ST_IDLE: begin
					if (exec && msg_code == rmi_pkg::RMI_COM_Q) begin
						st     <= rmi_pkg::RMI_ST_COMQ;
						com_ix <= 6'h00;
					end else if (exec && query_val_used(msg_code)) begin
						resp_valid <= 1'b1;
						resp_data  <= query_val;
						resp_last  <= msg_code != rmi_pkg::RMI_IDN_Q;
						if (msg_code == rmi_pkg::RMI_IDN_Q) begin
							st <= rmi_pkg::RMI_ST_IDN2;
						end
					end
				end
				rmi_pkg::RMI_ST_IDN2: begin
					resp_valid <= 1'b1;
					resp_data  <= rmi_pkg::ROM_WORD;
					resp_last  <= 1'b1;
					st         <= rmi_pkg::RMI_ST_IDLE;
				end
				// comment answer, one char per cycle
				rmi_pkg::RMI_ST_COMQ: begin
					resp_valid <= 1'b1;
					resp_data  <= {8'h00, com_mem[com_ix]};
					resp_last  <= com_ix == rmi_pkg::COM_LAST_IX;
					com_ix     <= com_ix + 6'h01;
					if (com_ix == rmi_pkg::COM_LAST_IX) begin
						st <= rmi_pkg::RMI_ST_IDLE;
					end
				end
				default: st <= rmi_pkg::RMI_ST_IDLE;
			endcase
		end
	end

	// queries that answer with one word from query_val
	function automatic logic query_val_used(input logic [4:0] c);
		case (c)
			rmi_pkg::RMI_ESR_Q, rmi_pkg::RMI_SRE_Q, rmi_pkg::RMI_STB_Q, rmi_pkg::RMI_BUZZ_Q,
			rmi_pkg::RMI_LDC_Q, rmi_pkg::RMI_CUR_Q, rmi_pkg::RMI_DAC_Q, rmi_pkg::RMI_DSM_Q,
			rmi_pkg::RMI_DSR_Q, rmi_pkg::RMI_ERR_Q, rmi_pkg::RMI_FAIL_Q,
			rmi_pkg::RMI_IDN_Q: query_val_used = 1'b1;
			default: query_val_used = 1'b0;
		endcase
	endfunction : query_val_used

	// checks
	a_exe_on_block: assert property (@(posedge sys_clk) disable iff (rst)
		blocked |=> esr[rmi_pkg::EXEC_FAULT_BIT] && err[rmi_pkg::ERR_INVAL_BIT])
		else $error("blocked message did not set execution fault");
	a_cme_on_fault: assert property (@(posedge sys_clk) disable iff (rst)
		fault |=> esr[rmi_pkg::CMD_FAULT_BIT])
		else $error("faulty message did not set command fault");
	a_esr_read_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(exec && msg_code == rmi_pkg::RMI_ESR_Q && !blocked && !fault) |=>
		resp_valid && resp_data == {8'h00, $past(esr)} && esr == 8'h00)
		else $error("event status read did not answer then clear");
	a_cls_clears: assert property (@(posedge sys_clk) disable iff (rst)
		(exec && msg_code == rmi_pkg::RMI_CLS) |=> err == 8'h00 && dsr == $past(dsr_set))
		else $error("clear-status left a register set");
	a_idn_two_words: assert property (@(posedge sys_clk) disable iff (rst)
		(exec && msg_code == rmi_pkg::RMI_IDN_Q) |=> resp_valid && !resp_last &&
		resp_data == rmi_pkg::MODEL_WORD ##1 resp_valid && resp_last && resp_data == rmi_pkg::ROM_WORD)
		else $error("identify answer malformed");
	a_buzz_guard: assert property (@(posedge sys_clk) disable iff (rst)
		(acc && msg_code == rmi_pkg::RMI_BUZZ && (test_q || prot_q)) |=> $stable(buzzer_loudness))
		else $error("buzzer changed while refused");
	a_sre_update: assert property (@(posedge sys_clk) disable iff (rst)
		(exec && msg_code == rmi_pkg::RMI_SRE) |=> sre == $past(msg_data[7:0]))
		else $error("service enable not stored");
	a_cur_in_test: assert property (@(posedge sys_clk) disable iff (rst)
		(acc && msg_code == rmi_pkg::RMI_CUR && test_q && !prot_q && !fault) |=>
		test_current == $past(msg_data[8:0]))
		else $error("current setting refused during test");
	a_query_always: assert property (@(posedge sys_clk) disable iff (rst)
		(acc && !fault && (msg_code == rmi_pkg::RMI_FAIL_Q || msg_code == rmi_pkg::RMI_DSR_Q)) |=> resp_valid)
		else $error("status query not answered");
	a_com_stream: assert property (@(posedge sys_clk) disable iff (rst)
		(exec && msg_code == rmi_pkg::RMI_COM_Q) |=> !msg_ready [*8])
		else $error("comment answer did not hold off messages");
endmodule : rmi_interp
`default_nettype wire

// ---- bench/rmi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host side of the parsed message handshake
module rmi_host_model (
	input  wire logic        sys_clk,        // system clock
	input  wire logic        msg_ready,      // interpreter can take a message
	output logic             msg_valid,      // message present
	output logic [4:0]       msg_code,       // message code
	output logic             msg_short,      // short header spelling
	output logic [15:0]      msg_data,       // value or comment char
	output logic             msg_syntax_err, // header fault
	output logic             msg_data_err    // data fault
);
	// quiet code, data and error lines carry the inverse of the last request, so stale values never look right
	initial begin
		msg_valid      = 1'b0;
		msg_code       = 5'h1F;
		msg_short      = 1'b0;
		msg_data       = 16'hFFFF;
		msg_syntax_err = 1'b1;
		msg_data_err   = 1'b1;
	end
	// one request: idle gap, raise on a falling edge, hold until a rising edge takes it
	task automatic send(input logic [4:0] code, input logic [15:0] data, input logic [1:0] errs,
			input logic shrt, input int gap, output logic ok);
		int n;
		ok = 1'b0;
		repeat (gap) @(negedge sys_clk);
		@(negedge sys_clk);
		msg_short = shrt;
		msg_code  = code;
		msg_data  = data;
		{msg_data_err, msg_syntax_err} = errs;
		msg_valid = 1'b1;
		// ready is stable from the falling edge up to the taking edge
		for (n = 0; n < 200 && !ok; n++) begin
			if (n > 0) @(negedge sys_clk);
			ok = msg_ready;
			@(posedge sys_clk);
		end
		@(negedge sys_clk);
		msg_valid = 1'b0;
		msg_code  = ~code;
		msg_data  = ~data;
		{msg_data_err, msg_syntax_err} = ~errs;
	endtask : send
endmodule : rmi_host_model
`default_nettype wire

// ---- bench/test_remote_message_interpreter.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_remote_message_interpreter;
	logic        sys_clk = 1'b0;      // 25 MHz clock
	logic        rst     = 1'b1;      // reset, held at start
	logic        msg_valid, msg_ready, msg_short, msg_syntax_err, msg_data_err; // handshake
	logic [4:0]  msg_code;            // message code
	logic [15:0] msg_data, resp_data; // request value, answer word
	logic        test_running = 1'b0, prot_active = 1'b0, load_detect = 1'b0; // pins
	logic [7:0]  dsr_set = 8'h00, prot_set = 8'h00, fail_set = 8'h00, invs_set = 8'h00; // event pulses
	logic        resp_valid, resp_last, flush, test_start, contact_check, double_action, srq; // outputs
	logic [3:0]  buzzer_loudness;     // buzzer setting
	logic [8:0]  test_current;        // current setting
	int          num_errors = 0;      // mismatches
	int          tests_run  = 0;      // comparisons
	int          i;                   // loop index
	logic [31:0] seed = 32'h00003E5A; // xorshift state
	logic [4:0]  gc;                  // drawn code
	logic [15:0] gd;                  // drawn data
	logic [1:0]  ge;                  // drawn parser flags
	// expected device state
	logic [7:0]  esr = 8'h00, err = 8'h00, sre = 8'h00, device_status_mask_cmd = 8'h00, dsr = 8'h00, fl = 8'h00;
	logic [3:0]  bz = rmi_pkg::BUZZ_DEFAULT; // buzzer
	logic [8:0]  cu = rmi_pkg::CUR_DEFAULT;  // current
	logic        lc = 1'b0, da = 1'b0, tr = 1'b0, pr = 1'b0; // contact, double action, test, protection
	logic [7:0]  cm [rmi_pkg::COM_CHARS];    // comment text

	always #20 sys_clk = ~sys_clk;

	rmi_host_model i_rmi_host_model (.sys_clk, .msg_ready, .msg_valid, .msg_code, .msg_short, .msg_data,
		.msg_syntax_err, .msg_data_err);
	rmi_interp i_rmi_interp (.sys_clk, .rst, .msg_valid, .msg_ready, .msg_code, .msg_short, .msg_data,
		.msg_syntax_err, .msg_data_err, .test_running, .prot_active, .load_detect, .dsr_set, .prot_set,
		.fail_set, .invs_set, .resp_valid, .resp_data, .resp_last, .flush, .test_start, .buzzer_loudness,
		.contact_check, .test_current, .double_action, .srq);

	// xorshift draw
	function automatic logic [31:0] nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : nxt
	// status byte rebuilt from its sources
	function automatic logic [7:0] stb();
		logic [7:0] s;
		s    = {2'b00, |esr, 1'b0, |(dsr & device_status_mask_cmd), 3'b000};
		s[6] = |(s & sre);
		return s;
	endfunction : stb
	// fault bits; every detected fault kind is recorded side by side
	function automatic logic [2:0] fault(input logic [4:0] c, input logic [15:0] d, input logic [1:0] e);
		logic rng;
		rng = 1'b0;
		case (c)
			rmi_pkg::RMI_SRE, rmi_pkg::RMI_DSM: rng = d > rmi_pkg::MASK_MAX;
			rmi_pkg::RMI_BUZZ: rng = d < rmi_pkg::BUZZ_MIN || d > rmi_pkg::BUZZ_MAX;
			rmi_pkg::RMI_CUR: rng = d < rmi_pkg::CUR_MIN || d > rmi_pkg::CUR_MAX;
			rmi_pkg::RMI_COM: rng = d[7:0] < rmi_pkg::CHAR_MIN || d[7:0] > rmi_pkg::CHAR_MAX
				|| d[7:0] inside {8'h22, 8'h27, 8'h2C, 8'h40};
			default: rng = 1'b0;
		endcase
		return {rng, e[1], e[0] || c > rmi_pkg::RMI_LAST_CODE};
	endfunction : fault
	// messages barred in test or protection
	function automatic logic blocked(input logic [4:0] c);
		logic idle_only;
		idle_only = c inside {rmi_pkg::RMI_SRE, rmi_pkg::RMI_BUZZ, rmi_pkg::RMI_COM, rmi_pkg::RMI_LDC,
			rmi_pkg::RMI_DAC, rmi_pkg::RMI_DSM};
		return (tr && idle_only) || (pr && (idle_only || c == rmi_pkg::RMI_CUR));
	endfunction : blocked

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic close_out();
		if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out

	// random message; host values with bounds and strays beyond them
	task automatic gen(output logic [4:0] c, output logic [15:0] d, output logic [1:0] e);
		logic [31:0] r;
		r = nxt();
		c = 5'(r[31:27] % 24);
		e = (r[2:0] == 3'h0) ? 2'b01 : (r[2:0] == 3'h1) ? 2'b10 : 2'b00;
		d = {8'h00, r[15:8]};
		case (c)
			rmi_pkg::RMI_BUZZ: d = (r[2:0] == 3'h2) ? (r[3] ? 16'h0000 : rmi_pkg::BUZZ_MAX + 16'h0001)
				: r[4] ? (r[3] ? rmi_pkg::BUZZ_MIN : rmi_pkg::BUZZ_MAX) : rmi_pkg::BUZZ_MIN + r[15:8] % 16'h000A;
			rmi_pkg::RMI_CUR: d = (r[2:0] == 3'h2) ? (r[3] ? rmi_pkg::CUR_MIN - 16'h0001 : rmi_pkg::CUR_MAX + 16'h0001)
				: r[4] ? (r[3] ? rmi_pkg::CUR_MIN : rmi_pkg::CUR_MAX) : rmi_pkg::CUR_MIN + r[23:8] % 16'h010F;
			rmi_pkg::RMI_SRE, rmi_pkg::RMI_DSM: if (r[2:0] == 3'h2) d = 16'h0100;
			rmi_pkg::RMI_LDC, rmi_pkg::RMI_DAC: d = 16'(r[8]);
			rmi_pkg::RMI_COM: d = {1'b0, 2'(r[9:8] % 3), 5'(r[14:10] % 20),
				(r[2:0] == 3'h2) ? (r[3] ? 8'h7F : 8'h2C) : 8'h20 + 8'(r[23:16] % 95)};
			default: d = r[15:0];
		endcase
	endtask : gen

	// send one message, update the expected state, compare the answer and the settings
	task automatic run(input logic [4:0] c, input logic [15:0] d, input logic [1:0] e);
		logic [2:0]  f;
		logic [1:0]  k;
		logic [15:0] x;
		logic        ok;
		logic [31:0] r;
		int          j;
		f = fault(c, d, e);
		k = 2'h0;
		x = 16'h0000;
		r = nxt();
		if (f != 3'b000) begin
			esr[5]    = 1'b1;
			err[2:0] |= f;
		end else if (blocked(c)) begin
			esr[4] = 1'b1;
			err[3] = 1'b1;
		end else begin
			k = c inside {rmi_pkg::RMI_ESR_Q, rmi_pkg::RMI_SRE_Q, rmi_pkg::RMI_STB_Q, rmi_pkg::RMI_BUZZ_Q,
				rmi_pkg::RMI_LDC_Q, rmi_pkg::RMI_CUR_Q, rmi_pkg::RMI_DAC_Q, rmi_pkg::RMI_DSM_Q, rmi_pkg::RMI_DSR_Q,
				rmi_pkg::RMI_ERR_Q, rmi_pkg::RMI_FAIL_Q} ? 2'h1 : 2'h0;
			case (c)
				rmi_pkg::RMI_CLS: {esr, err, dsr, fl} = 32'h00000000;
				rmi_pkg::RMI_ESR_Q: begin x = 16'(esr); esr = 8'h00; end
				rmi_pkg::RMI_IDN_Q: k = 2'h2;
				// settings back to factory values, masks kept
				rmi_pkg::RMI_RST: begin bz = rmi_pkg::BUZZ_DEFAULT; cu = rmi_pkg::CUR_DEFAULT; {lc, da} = 2'b00;
					foreach (cm[n]) cm[n] = rmi_pkg::CHAR_SPACE; end
				rmi_pkg::RMI_SRE: sre = d[7:0];
				rmi_pkg::RMI_SRE_Q: x = 16'(sre);
				rmi_pkg::RMI_STB_Q: x = 16'(stb());
				rmi_pkg::RMI_BUZZ: bz = d[3:0];
				rmi_pkg::RMI_BUZZ_Q: x = 16'(bz);
				rmi_pkg::RMI_COM: cm[d[14:13] * 20 + d[12:8]] = d[7:0];
				rmi_pkg::RMI_COM_Q: k = 2'h3;
				rmi_pkg::RMI_LDC: lc = d[0];
				rmi_pkg::RMI_LDC_Q: x = 16'(lc);
				rmi_pkg::RMI_CUR: cu = d[8:0];
				rmi_pkg::RMI_CUR_Q: x = 16'(cu);
				rmi_pkg::RMI_DAC: da = d[0];
				rmi_pkg::RMI_DAC_Q: x = 16'(da);
				rmi_pkg::RMI_DSM: device_status_mask_cmd = d[7:0];
				rmi_pkg::RMI_DSM_Q: x = 16'(device_status_mask_cmd);
				rmi_pkg::RMI_DSR_Q: x = 16'(dsr);
				rmi_pkg::RMI_ERR_Q: x = 16'(err);
				rmi_pkg::RMI_FAIL_Q: x = 16'(fl);
				default: x = 16'h0000;
			endcase
		end
		i_rmi_host_model.send(c, d, e, r[4], int'(r[1:0]), ok);
		if (!ok) begin
			num_errors++;
			close_out();
		end
		check({resp_valid, resp_last, resp_data}, (k == 2'h1) ? {2'b11, x} : (k == 2'h2) ? {2'b10, rmi_pkg::MODEL_WORD}
			: {2'b00, resp_data});
		check(20'(flush), 20'(f == 3'b000 && c == rmi_pkg::RMI_FLUSH));
		check(20'({bz, lc, cu, da}), 20'({buzzer_loudness, contact_check, test_current, double_action}));
		check(20'(srq), 20'(|(stb() & sre)));
		if (k == 2'h2) begin
			@(negedge sys_clk);
			check({resp_valid, resp_last, resp_data}, {2'b11, rmi_pkg::ROM_WORD});
		end
		for (j = 0; k == 2'h3 && j < rmi_pkg::COM_CHARS; j++) begin
			@(negedge sys_clk);
			check({resp_valid, resp_last, resp_data}, {1'b1, j == rmi_pkg::COM_CHARS - 1, 8'h00, cm[j]});
		end
	endtask : run

	// move the pins and raise events off the clock edge, then let the synchronisers settle
	task automatic pins(input logic [31:0] r);
		@(negedge sys_clk);
		{test_running, prot_active, load_detect} = r[2:0];
		{dsr_set, fail_set, prot_set, invs_set} = r;
		dsr |= r[31:24];
		fl  |= r[23:16];
		@(negedge sys_clk);
		{dsr_set, fail_set, prot_set, invs_set} = 32'h00000000;
		repeat (3) @(negedge sys_clk);
		{tr, pr} = r[2:1];
	endtask : pins

	initial begin
		foreach (cm[n]) cm[n] = rmi_pkg::CHAR_SPACE;
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		check(20'({msg_ready, buzzer_loudness, test_current}), 20'({1'b1, bz, cu}));
		// corner cases: identity, last comment slot, excluded char, reset keeping the service request enable mask, flush
		run(rmi_pkg::RMI_IDN_Q, 16'h0000, 2'b00);
		run(rmi_pkg::RMI_COM, 16'h5341, 2'b00);
		run(rmi_pkg::RMI_COM, 16'h0040, 2'b00);
		run(rmi_pkg::RMI_COM_Q, 16'h0000, 2'b00);
		run(rmi_pkg::RMI_SRE, 16'h00FF, 2'b00);
		run(rmi_pkg::RMI_RST, 16'h0000, 2'b00);
		run(rmi_pkg::RMI_SRE_Q, 16'h0000, 2'b00);
		run(rmi_pkg::RMI_COM_Q, 16'h0000, 2'b00);
		run(rmi_pkg::RMI_FLUSH, 16'h0000, 2'b00);
		run(rmi_pkg::RMI_ERR_Q, 16'h0000, 2'b00);
		// random traffic with test and protection states changing under it
		for (i = 0; i < 240; i++) begin
			if (i % 8 == 0) pins(nxt());
			gen(gc, gd, ge);
			run(gc, gd, ge);
		end
		// load arrival starts the test when contact check is on
		pins(32'h00000000);
		run(rmi_pkg::RMI_LDC, 16'h0001, 2'b00);
		load_detect = 1'b1;
		for (i = 0; i < 8 && test_start !== 1'b1; i++) @(negedge sys_clk);
		check(20'(test_start), 20'h00001);
		close_out();
	end
endmodule : test_remote_message_interpreter
`default_nettype wire
